/* lwsp_sram_port.sv */
// late-write pipelined synchronous sram host port with byte writes
//
// Contract
// RL1 - Inputs are sampled on the rising edge of CLK; output enable, sleep and write also gate the data drivers at once.
// RL2 - The address is captured at the rising edge of a selected cycle and names the word accessed.
// RL3 - Chip select is captured at the edge and a high value makes the cycle a deselect cycle.
// RL4 - A low write input in a selected cycle stores every byte lane whose enable is low.
// RL5 - Byte enables only permit writes together with the write input and never affect reads.
// RL6 - The low-active output enable gates the data drivers at once, without the clock.
// RL7 - Sleep high keeps the data bus high impedance in the current and the next cycle.
// RL8 - A selected read drives the whole word of its address in the following cycle.
// RL9 - A write keeps the bus undriven in its address cycle and stores the word taken next cycle.
// RL10 - Lanes map to 9-bit slices and a write changes only the slices of enabled lanes.
// RL11 - A write with every byte enable high aborts: nothing changes and the bus stays undriven.
// RL12 - A deselect without sleep performs no access and leaves the bus undriven next cycle.
// RL13 - The data drivers are off from power-up until a read is performed.
// RL14 - Read data is driven only with output enable low, a prior selected read and no sleep.
`timescale 1ns/1ps
`default_nettype none
`include "lwsp_cfg.svh"

module lwsp_sram_port (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [`LWSP_ADDR_W-1:0] WORD_ADDR_IN,
    input wire logic CHIP_SEL_N,
    input wire logic WRITE_REQ_N,
    input wire logic [`LWSP_LANES-1:0] BYTE_LANE_WE_N,
    input wire logic OUT_EN_N,
    input wire logic SLEEP_REQ,
    input wire logic [`LWSP_DATA_W-1:0] DATA_BUS_IO_I,
    output logic [`LWSP_DATA_W-1:0] DATA_BUS_IO_O,
    output logic DATA_BUS_IO_OE
);

    ////////////////////////////////////////////////////////////////////////////////
    // storage and pipeline state

    logic [`LWSP_DATA_W-1:0] mem [`LWSP_DEPTH];
    lwsp_pkg::lwsp_cmd_t cmd_d;
    lwsp_pkg::lwsp_cmd_t cmd_q;
    logic [`LWSP_DATA_W-1:0] merged_word;
    logic [`LWSP_DATA_W-1:0] rd_word_d;
    logic [`LWSP_DATA_W-1:0] rd_word_q;
    logic rd_valid_q;
    logic mem_we;
    logic rd_take;
    logic wr_take;
    logic abort_take;
    logic bypass_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // decode of the inputs seen at the coming edge

    always_comb begin
        cmd_d.addr = WORD_ADDR_IN; // [RL2]
        // lanes held active high; only used when a write is decoded
        cmd_d.lanes = ~BYTE_LANE_WE_N; // [RL5]
        if (SLEEP_REQ) begin
            cmd_d.op = lwsp_pkg::LWSP_OP_IDLE; // [RL7]
        end else if (CHIP_SEL_N) begin
            cmd_d.op = lwsp_pkg::LWSP_OP_IDLE; // [RL3] [RL12]
        end else if (WRITE_REQ_N) begin
            cmd_d.op = lwsp_pkg::LWSP_OP_READ; // [RL8]
        end else if (BYTE_LANE_WE_N == `LWSP_LANES_OFF) begin
            cmd_d.op = lwsp_pkg::LWSP_OP_ABORT; // [RL11]
        end else begin
            cmd_d.op = lwsp_pkg::LWSP_OP_WRITE; // [RL4]
        end
    end

    always_comb begin
        rd_take = (cmd_d.op == lwsp_pkg::LWSP_OP_READ);
        wr_take = (cmd_d.op == lwsp_pkg::LWSP_OP_WRITE);
        abort_take = (cmd_d.op == lwsp_pkg::LWSP_OP_ABORT);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address and control capture

    always_ff @(posedge CLK or posedge RESET) begin // [RL1]
        if (RESET) begin
            cmd_q <= '{op: lwsp_pkg::LWSP_OP_IDLE, addr: '0, lanes: '0};
        end else begin
            cmd_q <= cmd_d; // [RL2]
        end
    end

    // only a write in its data cycle touches the array
    always_comb begin
        case (cmd_q.op)
            lwsp_pkg::LWSP_OP_WRITE: mem_we = 1'b1; // [RL9]
            lwsp_pkg::LWSP_OP_ABORT: mem_we = 1'b0; // [RL11]
            lwsp_pkg::LWSP_OP_READ: mem_we = 1'b0;
            lwsp_pkg::LWSP_OP_IDLE: mem_we = 1'b0;
            default: mem_we = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // late write: data of the cycle after the address merged lane by lane

    for (genvar g = 0; g < `LWSP_LANES; g++) begin : g_lane
        lwsp_lane_merge u_merge (
            .old_slice(mem[cmd_q.addr][g*`LWSP_LANE_W +: `LWSP_LANE_W]),
            .new_slice(DATA_BUS_IO_I[g*`LWSP_LANE_W +: `LWSP_LANE_W]), // [RL10]
            .wr_en(cmd_q.lanes[g]),
            .merged(merged_word[g*`LWSP_LANE_W +: `LWSP_LANE_W])
        );
    end

    // array has no reset, as a real sram keeps no defined content
    always_ff @(posedge CLK) begin
        if (mem_we) begin
            mem[cmd_q.addr] <= merged_word; // [RL9] [RL10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    // a read right behind a write to the same word sees the new data,
    // because the array is only updated at this very edge
    always_comb begin
        bypass_hit = mem_we && (cmd_q.addr == WORD_ADDR_IN);
        rd_word_d = bypass_hit ? merged_word : mem[WORD_ADDR_IN];
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rd_word_q <= `LWSP_RD_RESET;
        end else if (rd_take) begin
            rd_word_q <= rd_word_d; // [RL8]
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rd_valid_q <= 1'b0; // [RL13]
        end else begin
            rd_valid_q <= rd_take; // [RL12] [RL14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data bus drivers

    // a low write input also blanks the drivers, so an earlier read
    // never collides with the turnaround of a write
    lwsp_out_drive u_drive (
        .rd_word_q(rd_word_q),
        .rd_valid_q(rd_valid_q),
        .out_en_n(OUT_EN_N), // [RL6]
        .sleep_req(SLEEP_REQ), // [RL7]
        .write_req_n(WRITE_REQ_N), // [RL9]
        .data_o(DATA_BUS_IO_O),
        .data_oe(DATA_BUS_IO_OE) // [RL14]
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    read_drive_a: assert property ( // [RL8]
        rd_take ##1 (!OUT_EN_N && !SLEEP_REQ && WRITE_REQ_N) |-> DATA_BUS_IO_OE
    ) else $error("selected read not driven in next cycle");

    read_word_a: assert property ( // [RL8]
        (rd_take && !bypass_hit) |=>
            DATA_BUS_IO_O == mem[$past(WORD_ADDR_IN)]
    ) else $error("read word differs from stored word");

    write_full_a: assert property ( // [RL9]
        (wr_take && BYTE_LANE_WE_N == `LWSP_LANES_ALL) ##1 1'b1 |=>
            mem[$past(WORD_ADDR_IN, 2)] == $past(DATA_BUS_IO_I)
    ) else $error("full write did not store next cycle data");

    lane_only_a: assert property ( // [RL10]
        (wr_take && BYTE_LANE_WE_N == `LWSP_LANE0_ONLY) ##1 1'b1 |=>
            mem[$past(WORD_ADDR_IN, 2)] ==
            {$past(mem[cmd_q.addr][`LWSP_DATA_W-1:`LWSP_LANE_W]),
             $past(DATA_BUS_IO_I[`LWSP_LANE_W-1:0])}
    ) else $error("single lane write touched other slices");

    abort_keep_a: assert property ( // [RL11]
        abort_take |=> !mem_we && !DATA_BUS_IO_OE
    ) else $error("aborted write changed array or drove bus");

    deselect_hiz_a: assert property ( // [RL12]
        (CHIP_SEL_N && !SLEEP_REQ) |=> !DATA_BUS_IO_OE && !mem_we
    ) else $error("deselect cycle performed an access");

    sleep_hiz_a: assert property ( // [RL7]
        SLEEP_REQ |-> !DATA_BUS_IO_OE ##1 !DATA_BUS_IO_OE
    ) else $error("bus driven during or after sleep");

    oe_async_a: assert property ( // [RL6]
        OUT_EN_N |-> !DATA_BUS_IO_OE
    ) else $error("bus driven with output enable high");

    write_turn_a: assert property ( // [RL9]
        !WRITE_REQ_N |-> !DATA_BUS_IO_OE ##1 (!DATA_BUS_IO_OE || rd_valid_q)
    ) else $error("bus driven in a write cycle");

    drive_cause_a: assert property ( // [RL14]
        DATA_BUS_IO_OE |-> $past(rd_take) && !OUT_EN_N && !SLEEP_REQ
    ) else $error("bus driven without a prior selected read");

    ////////////////////////////////////////////////////////////////////////////////
    // array contents, pipeline and reset checks

    // reset must silence the drivers even with a read pending
    drivers_off_a: assert property ( // [RL13]
        disable iff (1'b0) RESET |-> !DATA_BUS_IO_OE
    ) else $error("bus driven during reset");

    reset_quiet_a: assert property ( // [RL13]
        $fell(RESET) |-> !DATA_BUS_IO_OE && !rd_valid_q
    ) else $error("bus driven right after reset");

    write_store_a: assert property ( // [RL4]
        wr_take |=> mem_we
    ) else $error("selected write not stored in its data cycle");

    addr_word_a: assert property ( // [RL2]
        wr_take |=> cmd_q.addr == $past(WORD_ADDR_IN)
    ) else $error("write location differs from captured address");

    read_decode_a: assert property ( // [RL5]
        (!SLEEP_REQ && !CHIP_SEL_N && WRITE_REQ_N) |=> rd_valid_q && !mem_we
    ) else $error("read cycle changed by byte enables");

    bypass_word_a: assert property ( // [RL8]
        (rd_take && bypass_hit) |=>
            DATA_BUS_IO_O == mem[$past(WORD_ADDR_IN)]
    ) else $error("read behind a write missed the new word");

    word_hold_a: assert property ( // [RL8]
        !rd_take |=> $stable(DATA_BUS_IO_O)
    ) else $error("read word changed without a read");

    deselect_word_a: assert property ( // [RL12]
        (CHIP_SEL_N && !SLEEP_REQ) |=> $stable(DATA_BUS_IO_O)
    ) else $error("deselect cycle loaded a read word");

    // a read whose data cycle turns into a write is lost, not driven
    turn_lost_a: assert property ( // [RL9]
        rd_take ##1 !WRITE_REQ_N |-> !DATA_BUS_IO_OE
    ) else $error("read data driven into a write cycle");

    abort_array_a: assert property ( // [RL11]
        abort_take ##1 1'b1 |=>
            mem[$past(WORD_ADDR_IN, 2)] == $past(mem[cmd_q.addr])
    ) else $error("aborted write changed the stored word");

    sleep_next_a: assert property ( // [RL7]
        SLEEP_REQ |=> !mem_we && !rd_valid_q
    ) else $error("access performed in sleep mode");

    oe_drive_a: assert property ( // [RL14] [RL6]
        ($past(rd_take) && !OUT_EN_N && !SLEEP_REQ && WRITE_REQ_N) |-> DATA_BUS_IO_OE
    ) else $error("read data not driven with output enable low");

    // each lane checked alone, so a slip between slices shows
    for (genvar g = 0; g < `LWSP_LANES; g++) begin : g_lane_chk
        lane_keep_a: assert property ( // [RL10]
            (wr_take && BYTE_LANE_WE_N[g]) ##1 1'b1 |=>
                mem[$past(WORD_ADDR_IN, 2)][g*`LWSP_LANE_W +: `LWSP_LANE_W] ==
                $past(mem[cmd_q.addr][g*`LWSP_LANE_W +: `LWSP_LANE_W])
        ) else $error("disabled byte lane changed by a write");

        lane_take_a: assert property ( // [RL10]
            (wr_take && !BYTE_LANE_WE_N[g]) ##1 1'b1 |=>
                mem[$past(WORD_ADDR_IN, 2)][g*`LWSP_LANE_W +: `LWSP_LANE_W] ==
                $past(DATA_BUS_IO_I[g*`LWSP_LANE_W +: `LWSP_LANE_W])
        ) else $error("enabled byte lane not stored from data cycle");
    end

    read_cov: cover property (
        rd_take ##1 DATA_BUS_IO_OE
    );

    write_cov: cover property (
        wr_take && BYTE_LANE_WE_N == `LWSP_LANES_ALL ##1 mem_we
    );

    abort_cov: cover property (
        abort_take
    );

    bypass_cov: cover property (
        rd_take && bypass_hit ##1 DATA_BUS_IO_OE
    );

    sleep_cov: cover property (
        rd_take ##1 SLEEP_REQ
    );

endmodule : lwsp_sram_port
`default_nettype wire

/* lwsp_cfg.svh */
// constants of the late-write synchronous sram port
`ifndef LWSP_CFG_SVH
`define LWSP_CFG_SVH

// word location width, 128K words
`define LWSP_ADDR_W 17
`define LWSP_DEPTH (1 << `LWSP_ADDR_W)

// word and byte lane layout
`define LWSP_DATA_W 36
`define LWSP_LANE_W 9
`define LWSP_LANES 4

// byte lane enable patterns, active low
`define LWSP_LANES_OFF 4'hF
`define LWSP_LANES_ALL 4'h0
`define LWSP_LANE0_ONLY 4'hE

// reset value of the read word register
`define LWSP_RD_RESET 36'h0_0000_0000

// clock period of the host port
`define LWSP_CLK_PERIOD_NS 8

`endif

/* lwsp_pkg.sv */
// types shared by the late-write sram port modules
`include "lwsp_cfg.svh"

package lwsp_pkg;

    // kind of access captured at an address edge
    typedef enum logic [3:0] {
        LWSP_OP_IDLE = 4'h1,
        LWSP_OP_READ = 4'h2,
        LWSP_OP_WRITE = 4'h4,
        LWSP_OP_ABORT = 4'h8
    } lwsp_op_t;

    // access held from the address cycle into the data cycle
    typedef struct packed {
        lwsp_op_t op;
        logic [`LWSP_ADDR_W-1:0] addr;
        logic [`LWSP_LANES-1:0] lanes;
    } lwsp_cmd_t;

endpackage : lwsp_pkg

/* lwsp_lane_merge.sv */
// one byte lane: new slice when enabled, stored slice otherwise
`timescale 1ns/1ps
`default_nettype none
`include "lwsp_cfg.svh"

module lwsp_lane_merge (
    input wire logic [`LWSP_LANE_W-1:0] old_slice,
    input wire logic [`LWSP_LANE_W-1:0] new_slice,
    input wire logic wr_en,
    output logic [`LWSP_LANE_W-1:0] merged
);

    always_comb begin
        merged = wr_en ? new_slice : old_slice;
    end

endmodule : lwsp_lane_merge
`default_nettype wire

/* lwsp_out_drive.sv */
// data bus driver gating: output enable, sleep and write turnaround
`timescale 1ns/1ps
`default_nettype none
`include "lwsp_cfg.svh"

module lwsp_out_drive (
    input wire logic [`LWSP_DATA_W-1:0] rd_word_q,
    input wire logic rd_valid_q,
    input wire logic out_en_n,
    input wire logic sleep_req,
    input wire logic write_req_n,
    output logic [`LWSP_DATA_W-1:0] data_o,
    output logic data_oe
);

    // no clock in this path: output enable acts at once
    always_comb begin
        data_o = rd_word_q;
        data_oe = rd_valid_q & ~out_en_n & ~sleep_req & write_req_n;
    end

endmodule : lwsp_out_drive
`default_nettype wire

/* lwsp_ctl_model.sv */
// controller side of the data bus: write data and the resolved shared wire
`timescale 1ns/1ps
`default_nettype none
`include "lwsp_cfg.svh"

module lwsp_ctl_model (
    input wire logic clk,
    input wire logic [`LWSP_DATA_W-1:0] dev_o,
    input wire logic dev_oe,
    input wire logic [`LWSP_DATA_W-1:0] ctl_d,
    input wire logic ctl_en,
    output logic [`LWSP_DATA_W-1:0] bus
);
    // an undriven wire toggles with each clock level, twice a cycle, so stale data never passes as valid
    always_comb begin
        if (dev_oe) begin
            bus = dev_o;
        end else if (ctl_en) begin
            bus = ctl_d;
        end else begin
            bus = clk ? 36'hA_AAAA_AAAA : 36'h5_5555_5555;
        end
    end
endmodule : lwsp_ctl_model
`default_nettype wire

/* lwsp_sram_port_test.sv */
// self-checking bench of the late-write sram port
`timescale 1ns/1ps
`default_nettype none
`include "lwsp_cfg.svh"

module lwsp_sram_port_test;
    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic slp;
        logic [3:0] ln;
        logic [`LWSP_ADDR_W-1:0] a;
        logic [`LWSP_DATA_W-1:0] d;
        // expected drive in the data cycle, and the word read back after the row
        logic oe;
        logic [`LWSP_DATA_W-1:0] rb;
    } lwsp_row_t;
    localparam lwsp_row_t ROWS [11] = '{
        '{1'b0, 1'b0, 1'b0, 4'h0, 17'h00005, 36'h9_ABCD_1234, 1'b0, 36'h9_ABCD_1234},
        '{1'b0, 1'b0, 1'b0, 4'hE, 17'h00005, 36'h1_1111_1111, 1'b0, 36'h9_ABCD_1311},
        '{1'b0, 1'b0, 1'b0, 4'hD, 17'h00005, 36'h2_2222_2222, 1'b0, 36'h9_ABCE_2311},
        '{1'b0, 1'b0, 1'b0, 4'hB, 17'h00005, 36'h3_3333_3333, 1'b0, 36'h9_AB32_2311},
        '{1'b0, 1'b0, 1'b0, 4'h7, 17'h00005, 36'h4_4444_4444, 1'b0, 36'h4_4332_2311},
        '{1'b0, 1'b0, 1'b0, 4'hF, 17'h00005, 36'hF_FFFF_FFFF, 1'b0, 36'h4_4332_2311},
        '{1'b0, 1'b0, 1'b0, 4'h0, 17'h1FFFF, 36'h0_5A5A_5A5A, 1'b0, 36'h0_5A5A_5A5A},
        '{1'b1, 1'b0, 1'b0, 4'h0, 17'h00005, 36'h0_0000_0000, 1'b0, 36'h4_4332_2311},
        '{1'b1, 1'b1, 1'b0, 4'h0, 17'h00005, 36'h0_0000_0000, 1'b0, 36'h4_4332_2311},
        '{1'b0, 1'b0, 1'b1, 4'h0, 17'h00005, 36'h0_0000_0000, 1'b0, 36'h4_4332_2311},
        '{1'b0, 1'b1, 1'b1, 4'h0, 17'h00005, 36'h0_0000_0000, 1'b0, 36'h4_4332_2311}
    };
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cs_n = 1'b1;
    logic we_n = 1'b1;
    logic oe_n = 1'b0;
    logic slp = 1'b0;
    logic ctl_en = 1'b0;
    logic [3:0] ln = 4'hF;
    logic [`LWSP_ADDR_W-1:0] addr = '0;
    logic [`LWSP_DATA_W-1:0] ctl_d = '0;
    logic [`LWSP_DATA_W-1:0] bus;
    logic [`LWSP_DATA_W-1:0] dout;
    logic doe;
    int bad_count = 0;
    int checked = 0;

    always #4 clk = ~clk;

    lwsp_sram_port dut (.CLK(clk), .RESET(reset), .WORD_ADDR_IN(addr), .CHIP_SEL_N(cs_n),
        .WRITE_REQ_N(we_n), .BYTE_LANE_WE_N(ln), .OUT_EN_N(oe_n), .SLEEP_REQ(slp),
        .DATA_BUS_IO_I(bus), .DATA_BUS_IO_O(dout), .DATA_BUS_IO_OE(doe));
    lwsp_ctl_model ctl (.clk(clk), .dev_o(dout), .dev_oe(doe), .ctl_d(ctl_d),
        .ctl_en(ctl_en), .bus(bus));

    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // two cycles: controls, then data cycle with a deselect behind it
    task automatic run(input lwsp_row_t r);
        {cs_n, we_n, slp, ln, addr} = {r.cs_n, r.we_n, r.slp, r.ln, r.a};
        #1;
        if (!r.we_n) chk("oe_addr", doe, 1'b0);
        @(negedge clk);
        {cs_n, we_n, slp, ln, ctl_d, ctl_en} = {3'b110, 4'hF, r.d, !r.we_n};
        #1;
        chk("oe", doe, r.oe);
        if (r.oe) chk("rdata", dout, r.rb);
        @(negedge clk);
        ctl_en = 1'b0;
    endtask : run

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20) @(negedge clk);
        chk("oe_reset", doe, 1'b0);
        reset = 1'b0;
        @(negedge clk);
        chk("oe_powerup", doe, 1'b0);
        foreach (ROWS[i]) begin
            run(ROWS[i]);
            run('{1'b0, 1'b1, 1'b0, 4'h0, ROWS[i].a, 36'h0, 1'b1, ROWS[i].rb});
        end
        // write then read of the same word back to back
        {cs_n, we_n, ln, addr} = {2'b00, 4'h0, 17'h00009};
        @(negedge clk);
        {we_n, ctl_d, ctl_en} = {1'b1, 36'hC_3C3C_3C3C, 1'b1};
        @(negedge clk);
        {cs_n, ctl_en} = 2'b10;
        #1;
        chk("bypass", dout, 36'hC_3C3C_3C3C);
        oe_n = 1'b1;
        #1;
        chk("oe_async", doe, 1'b0);
        {oe_n, slp} = 2'b01;
        #1;
        chk("oe_sleep", doe, 1'b0);
        slp = 1'b0;
        #1;
        chk("oe_back", doe, 1'b1);
        // read of word 9 with an aborted write behind it: the read is lost
        @(negedge clk);
        {cs_n, addr} = {1'b0, 17'h00009};
        @(negedge clk);
        {we_n, ln} = {1'b0, 4'hF};
        #1;
        chk("oe_turn", doe, 1'b0);
        @(negedge clk);
        we_n = 1'b1;
        @(negedge clk);
        cs_n = 1'b1;
        #1;
        chk("abort_keep", dout, 36'hC_3C3C_3C3C);
        chk("oe_reread", doe, 1'b1);
        // reset in mid-run while the read word is being driven
        reset = 1'b1;
        #1;
        chk("oe_midreset", doe, 1'b0);
        chk("rd_midreset", dout, `LWSP_RD_RESET);
        repeat (2) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk("oe_rerelease", doe, 1'b0);
        conclude();
    end

    initial begin
        #20000;
        bad_count++;
        conclude();
    end
endmodule : lwsp_sram_port_test
`default_nettype wire
